// ===== shared/acts_pkg.sv
/*
  constants for the converter timing sequencer: cycle rate, timing unit,
  phase lengths per timing selection, state codes and result limits.
  assumes the sequencer clock is the cpu clock itself.
*/
`default_nettype none
package acts_pkg;

  // clock and timing unit, unit is half a cpu clock period
  localparam int CLK_PERIOD_NS = 50;
  localparam int UNIT_NS = CLK_PERIOD_NS / 2;

  // converter width and result limits
  localparam int RES_W = 10;
  localparam int CNT_W = 11;
  localparam logic [9:0] RESULT_MIN = 10'h000;
  localparam logic [9:0] RESULT_MAX = 10'h3ff;
  localparam logic [9:0] TRIAL_MSB = 10'h200;
  localparam logic [3:0] MSB_INDEX = 4'h9;

  // control register field positions (upper four bits)
  localparam int SAMPLE_SEL_LSB = 12;
  localparam int CONV_SEL_LSB = 14;

  // conversion clock select codes; 01 is reserved
  localparam logic [1:0] CONV_SEL_FAST = 2'h0;
  localparam logic [1:0] CONV_SEL_RSVD = 2'h1;
  localparam logic [1:0] CONV_SEL_SLOW = 2'h2;
  localparam logic [1:0] CONV_SEL_MID = 2'h3;

  // phase lengths in timing units, index {row, sample_time_select}
  // row 0: select 00, row 1: select 11, row 2: select 10
  localparam logic [11:0] SAMPLE_UNITS [0:11] = '{
    12'd120, 12'd140, 12'd200, 12'd400,
    12'd240, 12'd280, 12'd400, 12'd800,
    12'd480, 12'd560, 12'd800, 12'd1600};
  localparam logic [11:0] COMPARE_UNITS [0:11] = '{
    12'd240, 12'd280, 12'd280, 12'd280,
    12'd480, 12'd560, 12'd560, 12'd560,
    12'd960, 12'd1120, 12'd1120, 12'd1120};
  localparam logic [11:0] EXTRA_UNITS [0:11] = '{
    12'd28, 12'd16, 12'd52, 12'd44,
    12'd52, 12'd28, 12'd100, 12'd52,
    12'd100, 12'd52, 12'd196, 12'd164};

  // comparison phase is split evenly over the approximation steps
  localparam int SAR_STEPS = 10;

  // reset values
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [CNT_W-1:0] COUNT_RST = 11'h000;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_COMPARE = 4'b0100,
    ST_EXTRA = 4'b1000
  } acts_state_t;

endpackage : acts_pkg
`default_nettype wire

// ===== design/acts_phase_timer.sv
/*
  down counter that times one phase or one step.
  assumes load is a one-cycle strobe and load_val is at least one.
*/
`timescale 1ns/1ns
`default_nettype none
module acts_phase_timer (
  input wire logic clk, // cpu clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic load, // start a new interval
  input wire logic [10:0] load_val, // interval length in cycles
  output logic last // final cycle of the interval
);

  logic [10:0] count_ff;

  ////////////////////////////////////////////////////////////////////////
  // count down to zero, reload wins over counting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_ff <= acts_pkg::COUNT_RST;
    end else if (load) begin
      count_ff <= load_val;
    end else if (count_ff != 11'h000) begin
      count_ff <= count_ff - 11'h001;
    end
  end

  assign last = (count_ff == 11'h001);

endmodule : acts_phase_timer
`default_nettype wire

// ===== design/acts_seq_top.sv
/*
  conversion timing sequencer for a 10-bit successive approximation
  converter: sample, compare and extra phases, clamp and power-off.
  assumes the analog front end samples while sample_switch is high and
  reports its comparator and range detectors synchronous to clk.
*/
// Functional notes
// - timing comes from two 2-bit selects in the control register's top four bits
// - phases counted in half cpu period units, two units per clock cycle
// - conversion runs sample, comparison steps, then extra result-load phase
// - clock select 00 gives the first row of sample, compare, extra lengths
// - clock select 11 gives the row with doubled sample and compare lengths
// - clock select 10 gives the row with quadrupled sample and compare lengths
// - input captured only during sample phase; later changes ignored
// - input below ground gives 0x000, above reference gives 0x3ff
// - power-off bit switches analog circuitry off
// - sampled input compared with reference, 10-bit code, step ref/1024
`timescale 1ns/1ns
`default_nettype none
module acts_seq_top (
  input wire logic clk, // cpu clock, 20 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic start, // request one conversion
  input wire logic [15:0] converter_control_reg, // converter control word
  input wire logic converter_power_off, // switch analog part off
  input wire logic comp_in_ge_dac, // comparator: sampled input >= dac level
  input wire logic in_below_gnd, // input under the ground pin level
  input wire logic in_above_ref, // input over the reference pin level
  output logic analog_on, // analog circuitry powered
  output logic sample_switch, // input switch closed, sampling
  output logic [9:0] dac_code, // trial code to the dac
  output logic [9:0] result, // result register
  output logic done, // one-cycle completion strobe
  output logic busy // conversion in progress
);

  acts_pkg::acts_state_t state_ff;
  acts_pkg::acts_state_t nxt_state;
  logic [3:0] tsel_ff;
  logic [3:0] tbl_idx;
  logic [3:0] bit_idx_ff;
  logic [9:0] code_ff;
  logic [9:0] result_ff;
  logic low_ff;
  logic high_ff;
  logic done_ff;
  logic busy_ff;
  logic sample_switch_ff;
  logic analog_on_ff;
  logic load;
  logic [10:0] load_val;
  logic last;
  logic [10:0] sample_cyc;
  logic [10:0] step_cyc;
  logic [10:0] extra_cyc;
  logic go;

  ////////////////////////////////////////////////////////////////////////
  // timing lookup from the latched selection

  // map clock select to a table row; reserved 01 falls back to row 0
  function automatic logic [1:0] row_of(input logic [1:0] ctc);
    case (ctc)
      acts_pkg::CONV_SEL_MID: row_of = 2'h1;
      acts_pkg::CONV_SEL_SLOW: row_of = 2'h2;
      default: row_of = 2'h0;
    endcase
  endfunction : row_of

  // units to cycles: unit is half the clock period
  function automatic logic [10:0] to_cyc(input logic [11:0] units);
    int c;
    c = int'(units) * acts_pkg::UNIT_NS / acts_pkg::CLK_PERIOD_NS;
    if (c < 1) c = 1;
    to_cyc = c[10:0];
  endfunction : to_cyc

  assign tbl_idx = {row_of(tsel_ff[3:2]), tsel_ff[1:0]};
  assign sample_cyc = to_cyc(acts_pkg::SAMPLE_UNITS[tbl_idx]);
  assign step_cyc = to_cyc(acts_pkg::COMPARE_UNITS[tbl_idx] / 12'(acts_pkg::SAR_STEPS));
  assign extra_cyc = to_cyc(acts_pkg::EXTRA_UNITS[tbl_idx]);

  assign go = start && !converter_power_off && (state_ff == acts_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // selection snapshot, taken when a conversion starts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tsel_ff <= 4'h0;
    end else if (go) begin
      tsel_ff <= converter_control_reg[acts_pkg::SAMPLE_SEL_LSB +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase sequencing
  always_comb begin
    nxt_state = state_ff;
    load = 1'b0;
    load_val = sample_cyc;
    case (state_ff)
      acts_pkg::ST_IDLE: begin
        if (go) begin
          nxt_state = acts_pkg::ST_SAMPLE;
          load = 1'b1;
          load_val = to_cyc(acts_pkg::SAMPLE_UNITS[{row_of(converter_control_reg[acts_pkg::CONV_SEL_LSB +: 2]),
                                                   converter_control_reg[acts_pkg::SAMPLE_SEL_LSB +: 2]}]);
        end
      end
      acts_pkg::ST_SAMPLE: begin
        if (last) begin
          nxt_state = acts_pkg::ST_COMPARE;
          load = 1'b1;
          load_val = step_cyc;
        end
      end
      acts_pkg::ST_COMPARE: begin
        if (last) begin
          load = 1'b1;
          if (bit_idx_ff == 4'h0) begin
            nxt_state = acts_pkg::ST_EXTRA;
            load_val = extra_cyc;
          end else begin
            load_val = step_cyc;
          end
        end
      end
      acts_pkg::ST_EXTRA: begin
        if (last) begin
          nxt_state = acts_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = acts_pkg::ST_IDLE;
      end
    endcase
    // power-off aborts any conversion
    if (converter_power_off) begin
      nxt_state = acts_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= acts_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  acts_phase_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(load),
    .load_val(load_val),
    .last(last)
  );

  ////////////////////////////////////////////////////////////////////////
  // analog controls; switch opens at the end of sampling so the
  // held charge is what gets converted
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sample_switch_ff <= 1'b0;
      analog_on_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      sample_switch_ff <= (nxt_state == acts_pkg::ST_SAMPLE);
      analog_on_ff <= !converter_power_off;
      busy_ff <= (nxt_state != acts_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // range detectors read only while the switch is closed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_ff <= 1'b0;
      high_ff <= 1'b0;
    end else if (go) begin
      low_ff <= 1'b0;
      high_ff <= 1'b0;
    end else if (state_ff == acts_pkg::ST_SAMPLE && last) begin
      low_ff <= in_below_gnd;
      high_ff <= in_above_ref;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // successive approximation, msb first, one bit per step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_ff <= acts_pkg::RESULT_RST;
      bit_idx_ff <= acts_pkg::MSB_INDEX;
    end else if (state_ff == acts_pkg::ST_SAMPLE && last) begin
      code_ff <= acts_pkg::TRIAL_MSB;
      bit_idx_ff <= acts_pkg::MSB_INDEX;
    end else if (state_ff == acts_pkg::ST_COMPARE && last) begin
      // keep the trial bit only if the input reaches the dac level
      code_ff[bit_idx_ff] <= comp_in_ge_dac;
      if (bit_idx_ff != 4'h0) begin
        code_ff[bit_idx_ff - 4'h1] <= 1'b1;
        bit_idx_ff <= bit_idx_ff - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result load and completion strobe in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_ff <= acts_pkg::RESULT_RST;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (state_ff == acts_pkg::ST_EXTRA && last && !converter_power_off) begin
        done_ff <= 1'b1;
        if (low_ff) begin
          result_ff <= acts_pkg::RESULT_MIN;
        end else if (high_ff) begin
          result_ff <= acts_pkg::RESULT_MAX;
        end else begin
          result_ff <= code_ff;
        end
      end
    end
  end

  assign analog_on = analog_on_ff;
  assign sample_switch = sample_switch_ff;
  assign dac_code = code_ff;
  assign result = result_ff;
  assign done = done_ff;
  assign busy = busy_ff;

endmodule : acts_seq_top
`default_nettype wire

// ===== tb/acts_seq_assertions.sv
/* port checker for the conversion sequencer.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module acts_seq_assertions (
  input wire logic clk, // cpu clock
  input wire logic rst_n, // reset, active low
  input wire logic start, // request
  input wire logic [15:0] converter_control_reg, // selects
  input wire logic converter_power_off, // power off
  input wire logic in_below_gnd, // under ground
  input wire logic in_above_ref, // over reference
  input wire logic analog_on, // powered
  input wire logic sample_switch, // sampling
  input wire logic [9:0] dac_code, // trial code
  input wire logic [9:0] result, // result
  input wire logic done, // done strobe
  input wire logic busy // busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic below_ff;
  logic above_ff;
  // range flags as last seen while sampling
  always_ff @(posedge clk) begin
    if (sample_switch) begin
      below_ff <= in_below_gnd;
      above_ff <= in_above_ref;
    end
  end
  //////////////////////////////////////////////////////////////////////
  sequence s_take;
    start && !busy && !converter_power_off && converter_control_reg[15:12] == 4'h0;
  endsequence
  sequence s_sample;
    ##1 sample_switch ##59 sample_switch ##1 !sample_switch;
  endsequence
  property p_sample_len;
    disable iff (!rst_n || converter_power_off) s_take |-> s_sample;
  endproperty
  property p_total;
    disable iff (!rst_n || converter_power_off) s_take |-> ##195 done;
  endproperty
  property p_start;
    start && !busy && !converter_power_off |=> busy && sample_switch;
  endproperty
  property p_done_pulse;
    done |=> !done;
  endproperty
  property p_low;
    done && below_ff |-> result == 10'h000;
  endproperty
  property p_high;
    done && above_ff && !below_ff |-> result == 10'h3ff;
  endproperty
  property p_power;
    converter_power_off |=> !analog_on && !busy;
  endproperty
  property p_result;
    $changed(result) |-> done;
  endproperty
  property p_first_trial;
    // an aborted sample drops busy with the switch, so only a finished sample counts
    disable iff (!rst_n || converter_power_off) $fell(sample_switch) && busy |-> dac_code == 10'h200;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample length wrong");
  a_total: assert property (p_total) else $error("done late or early");
  a_start: assert property (p_start) else $error("start not taken");
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  a_low: assert property (p_low) else $error("low clamp wrong");
  a_high: assert property (p_high) else $error("high clamp wrong");
  a_power: assert property (p_power) else $error("power off ignored");
  a_result: assert property (p_result) else $error("result moved without done");
  a_first_trial: assert property (p_first_trial) else $error("first trial wrong");
endmodule : acts_seq_assertions
bind acts_seq_top acts_seq_assertions u_chk (.clk(clk), .rst_n(rst_n), .start(start),
  .converter_control_reg(converter_control_reg), .converter_power_off(converter_power_off),
  .in_below_gnd(in_below_gnd), .in_above_ref(in_above_ref), .analog_on(analog_on),
  .sample_switch(sample_switch), .dac_code(dac_code), .result(result), .done(done), .busy(busy));
`default_nettype wire

// ===== tb/acts_front_model.sv
/* analog front end model: sample switch, comparator, range detectors.
   assumes levels are given in converter steps. */
`timescale 1ns/1ns
`default_nettype none
module acts_front_model (
  input wire logic clk, // cpu clock
  input wire logic analog_on, // powered
  input wire logic sample_switch, // switch closed
  input wire logic [9:0] dac_code, // trial code
  input wire logic [9:0] vin, // input level
  input wire logic below_in, // input under ground
  input wire logic above_in, // input over reference
  output logic comp_in_ge_dac, // comparator
  output logic in_below_gnd, // range low
  output logic in_above_ref // range high
);
  logic [9:0] held_ff;
  logic tog_ff = 1'b0;
  // follow the level while the switch is closed, keep it once the switch opens
  always @(posedge clk) begin
    if (sample_switch) begin
      held_ff <= vin;
    end
    tog_ff <= !tog_ff;
  end
  // unpowered comparator gives no stable answer
  assign comp_in_ge_dac = analog_on ? (held_ff >= dac_code) : tog_ff;
  assign in_below_gnd = below_in;
  assign in_above_ref = above_in;
endmodule : acts_front_model
`default_nettype wire

// ===== tb/acts_seq_top_test.sv
/* self-checking bench for the conversion sequencer.
   assumes package, design and model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module acts_seq_top_test;
  typedef struct {logic [9:0] res; int at;} acts_note_t;
  logic clk, rst_n, start, pwr_off, below, above, analog_on, sample_switch, done, busy, cmp, bg, ab;
  logic [15:0] ctrl;
  logic [9:0] vin, dac_code, result;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  acts_note_t notes[$];
  acts_note_t nt_m;
  acts_seq_top dut (.clk(clk), .rst_n(rst_n), .start(start), .converter_control_reg(ctrl),
    .converter_power_off(pwr_off), .comp_in_ge_dac(cmp), .in_below_gnd(bg), .in_above_ref(ab),
    .analog_on(analog_on), .sample_switch(sample_switch), .dac_code(dac_code), .result(result),
    .done(done), .busy(busy));
  acts_front_model fe (.clk(clk), .analog_on(analog_on), .sample_switch(sample_switch),
    .dac_code(dac_code), .vin(vin), .below_in(below), .above_in(above), .comp_in_ge_dac(cmp),
    .in_below_gnd(bg), .in_above_ref(ab));
  //////////////////////////////////////////////////////////////////////
  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk_res(input string nm, input logic [9:0] e, input logic [9:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_res
  task automatic chk_cyc(input string nm, input int e, input int s);
    n_compared++;
    if (s != e) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
    end
  endtask : chk_cyc
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  // one conversion; note expected code and done cycle, then disturb input
  task automatic conv(input logic [1:0] cs, input logic [1:0] ss, input logic b, input logic a);
    int r;
    int n;
    acts_note_t nt;
    r = (cs == 2'h3) ? 4 : (cs == 2'h2) ? 8 : 0; // reserved 01 timed as 00
    r = r + ss;
    ctrl = {cs, ss, 12'($urandom)};
    vin = 10'($urandom);
    below = b;
    above = a;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    nt.res = b ? acts_pkg::RESULT_MIN : a ? acts_pkg::RESULT_MAX : vin;
    nt.at = cyc + int'(acts_pkg::SAMPLE_UNITS[r] + acts_pkg::COMPARE_UNITS[r] + acts_pkg::EXTRA_UNITS[r]) / 2;
    notes.push_back(nt);
    for (n = 0; n < 900 && sample_switch === 1'b1; n++) @(posedge clk) #1;
    vin = ~vin;
    below = !b;
    above = !a;
    start = 1'b1; // refused while busy
    @(posedge clk);
    #1 start = 1'b0;
    for (n = 0; n < 2000 && done !== 1'b1; n++) @(posedge clk) #1;
    // a wait that runs out is a failure of its own
    if (n == 2000) begin
      fail_count++;
    end
  endtask : conv
  // match each completion against the oldest note
  always @(negedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        chk_cyc("unexpected done", 0, 1);
      end else begin
        nt_m = notes.pop_front();
        chk_res("result", nt_m.res, result);
        chk_cyc("done cycle", nt_m.at, cyc);
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int cs;
    int ss;
    void'($urandom(32'h2271a577));
    rst_n = 1'b0;
    start = 1'b0;
    pwr_off = 1'b0;
    below = 1'b0;
    above = 1'b0;
    ctrl = 16'h0000;
    vin = 10'h000;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    for (cs = 0; cs < 4; cs++) begin
      for (ss = 0; ss < 4; ss++) begin
        // software never programs the reserved clock select 01
        if (cs != 1) begin
          conv(2'(cs), 2'(ss), 1'b0, 1'b0);
        end
      end
    end
    conv(2'h3, 2'h0, 1'b1, 1'b1);
    conv(2'h0, 2'h2, 1'b0, 1'b1);
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    repeat (10) @(posedge clk);
    #1 pwr_off = 1'b1;
    start = 1'b1;
    @(posedge clk);
    #1 chk_res("analog_on", 10'h000, {9'h000, analog_on});
    chk_res("held result", acts_pkg::RESULT_MAX, result);
    start = 1'b0;
    pwr_off = 1'b0;
    @(posedge clk);
    #1 chk_res("analog_on", 10'h001, {9'h000, analog_on});
    conv(2'h2, 2'h3, 1'b0, 1'b0);
    // let the watcher take the last note off at the falling edge first
    @(posedge clk);
    chk_cyc("open notes", 0, notes.size());
    wrap_up();
  end
  // cut a hang short
  initial begin
    #(40000 * 50);
    fail_count++;
    wrap_up();
  end
endmodule : acts_seq_top_test
`default_nettype wire
